// ---- hw/pmd_diag_bank.sv ----
// Purpose: Manufacturer diagnostic and record commands of the converter management port
// Assumes: All inputs come from logic on clock; rst is the power-on reset
// Notes: One command per request pulse, answered on the next edge
//
// Function
// RULE1: A 4-byte block write to boot entry puts the device in boot mode.
// RULE2: Host sends boot entry, and has it accepted, before any firmware download.
// RULE3: Current-share threshold is an 8-byte readable and writable block.
// RULE4: Bit 56 of the threshold block enables active current sharing.
// RULE5: Ramp capture stores 15 input/output voltage byte pairs, read as 32 bytes.
// RULE6: Sample spacing scales with configured ramp time so 15 samples span it.
// RULE7: Counter in bits 15:0, pair n at 16 plus 16n upward.
// RULE8: Record counter is latched just before the ramp starts.
// RULE9: Latched counter equals last snapshot cycle count plus one.
// RULE10: Only the first ramp after power-up is captured.
// RULE11: Ramp log is cleared once a ramp-up completes successfully.
// RULE12: Sensor-select bit 0 picks internal sensor at 0, remote at 1.
// RULE13: Input offset block: turn-on trim in 31:16, turn-off in 15:0, read-only.
// RULE14: Output trim is a read-only signed 16-bit word in output mode format.
// RULE15: Status logging starts after the start-up ramp, lasts first 128 s.
// RULE16: Sixteen status words are stored, one every 8 seconds.
// RULE17: Status log reads as 32 bytes, word 0 in bits 15:0 upward.
// RULE18: Primary temperature from selected sensor, secondary from the other one.
// RULE19: Writes to read-only log and offset commands are refused, contents kept.
`timescale 1ns/1ps
`default_nettype none
module pmd_diag_bank
  import pmd_pkg::*;
#(
  parameter int STATUS_INTERVAL = STATUS_INTERVAL_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Command port from the protocol engine
  input wire pmd_req_type req,
  output pmd_resp_type resp,
  // Power stage events and samples
  input wire logic rampStart,
  input wire logic rampDone,
  input wire logic [31:0] rampTimeCyc,
  input wire logic [7:0] vinSample,
  input wire logic [7:0] voutSample,
  input wire logic [15:0] snapshotCount,
  input wire logic [15:0] statusWord,
  // Trim store and sensors
  input wire logic [15:0] vinOffsetOn,
  input wire logic [15:0] vinOffsetOff,
  input wire logic [15:0] voutTrim,
  input wire logic [15:0] intTemp,
  input wire logic [15:0] extTemp,
  // Controls to the rest of the device
  output logic bootMode,
  output logic shareEnable,
  output logic [15:0] primaryTemp,
  output logic [15:0] secondaryTemp
);
  ////////////////////////////////////////////////////////////////////////////////
  // Command decode and register file
  logic bootMode_r, bootMode_nxt;
  logic [63:0] shareThr_r, shareThr_nxt;
  logic [7:0] tempSel_r, tempSel_nxt;
  pmd_resp_type resp_r, resp_nxt;
  logic [255:0] rampRead, statRead;
  logic isRoCmd;

  assign isRoCmd = (req.code == CMD_RAMP_CAPTURE_LOG) || (req.code == CMD_INPUT_OFFSET_TRIM)
    || (req.code == CMD_OUTPUT_TRIM_MONITOR) || (req.code == CMD_STARTUP_STATUS_LOG);

  always_comb begin
    bootMode_nxt = bootMode_r;
    shareThr_nxt = shareThr_r;
    tempSel_nxt = tempSel_r;
    resp_nxt = '0;
    if (req.valid) begin
      resp_nxt.valid = 1'b1;
      if (req.write) begin
        // Read-only targets fall through to a refusal and keep their contents
        unique case (req.code)
          CMD_BOOT_MODE_ENTRY: begin
            if (req.len == LEN_BOOT) begin
              bootMode_nxt = 1'b1; // RULE1 RULE2
              resp_nxt.ack = 1'b1;
            end
          end
          CMD_CURRENT_SHARE_THRESHOLD: begin
            if (req.len == LEN_SHARE) begin
              shareThr_nxt = req.data[63:0]; // RULE3
              resp_nxt.ack = 1'b1;
            end
          end
          CMD_TEMP_SOURCE_SELECT: begin
            if (req.len == LEN_TSEL) begin
              tempSel_nxt = req.data[7:0]; // RULE12
              resp_nxt.ack = 1'b1;
            end
          end
          default: resp_nxt.ack = 1'b0; // RULE19
        endcase
      end else begin
        unique case (req.code)
          CMD_CURRENT_SHARE_THRESHOLD: begin
            resp_nxt.ack = 1'b1;
            resp_nxt.len = LEN_SHARE;
            resp_nxt.data[63:0] = shareThr_r; // RULE3
          end
          CMD_RAMP_CAPTURE_LOG: begin
            resp_nxt.ack = 1'b1;
            resp_nxt.len = LEN_RAMP;
            resp_nxt.data = rampRead; // RULE5
          end
          CMD_TEMP_SOURCE_SELECT: begin
            resp_nxt.ack = 1'b1;
            resp_nxt.len = LEN_TSEL;
            resp_nxt.data[7:0] = tempSel_r;
          end
          CMD_INPUT_OFFSET_TRIM: begin
            resp_nxt.ack = 1'b1;
            resp_nxt.len = LEN_VIN_OFS;
            resp_nxt.data[31:0] = {vinOffsetOn, vinOffsetOff}; // RULE13
          end
          CMD_OUTPUT_TRIM_MONITOR: begin
            resp_nxt.ack = 1'b1;
            resp_nxt.len = LEN_VOUT_TRIM;
            resp_nxt.data[15:0] = voutTrim; // RULE14
          end
          CMD_STARTUP_STATUS_LOG: begin
            resp_nxt.ack = 1'b1;
            resp_nxt.len = LEN_STATUS;
            resp_nxt.data = statRead; // RULE17
          end
          default: resp_nxt.ack = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bootMode_r <= 1'b0;
      shareThr_r <= SHARE_RESET;
      tempSel_r <= TSEL_RESET;
      resp_r <= '0;
    end else begin
      bootMode_r <= bootMode_nxt;
      shareThr_r <= shareThr_nxt;
      tempSel_r <= tempSel_nxt;
      resp_r <= resp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output flops
  logic shareEn_r;
  logic [15:0] priTemp_r, secTemp_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      shareEn_r <= 1'b0;
      priTemp_r <= 16'h0000;
      secTemp_r <= 16'h0000;
    end else begin
      shareEn_r <= shareThr_nxt[SHARE_EN_BIT]; // RULE4
      priTemp_r <= tempSel_r[TSEL_BIT] ? extTemp : intTemp; // RULE18
      secTemp_r <= tempSel_r[TSEL_BIT] ? intTemp : extTemp; // RULE18
    end
  end

  assign resp = resp_r;
  assign bootMode = bootMode_r;
  assign shareEnable = shareEn_r;
  assign primaryTemp = priTemp_r;
  assign secondaryTemp = secTemp_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Ramp capture
  // Spacing uses a rate accumulator instead of a divider: each cycle adds the pair
  // count, and a sample is due each time it passes the ramp time.
  pmd_ramp_type rampSt_r, rampSt_nxt;
  logic rampTaken_r, rampTaken_nxt;
  logic [15:0] rampCount_r, rampCount_nxt;
  logic [15:0] rampMem_r [RAMP_PAIRS];
  logic [15:0] rampWrData;
  logic [4:0] rampIdx_r, rampIdx_nxt;
  logic [32:0] rampAcc_r, rampAcc_nxt, rampSum;
  logic rampWrite, rampClear;

  assign rampSum = rampAcc_r + 33'(RAMP_PAIRS_W);
  assign rampWrData = {voutSample, vinSample};

  always_comb begin
    rampSt_nxt = rampSt_r;
    rampTaken_nxt = rampTaken_r;
    rampCount_nxt = rampCount_r;
    rampIdx_nxt = rampIdx_r;
    rampAcc_nxt = rampAcc_r;
    rampWrite = 1'b0;
    rampClear = 1'b0;
    unique case (rampSt_r)
      RAMP_IDLE: begin
        if (rampStart && !rampTaken_r) begin // RULE10
          rampCount_nxt = snapshotCount + 16'h0001; // RULE8 RULE9
          rampTaken_nxt = 1'b1;
          rampIdx_nxt = 5'h00;
          rampAcc_nxt = 33'h0_0000_0000;
          rampSt_nxt = RAMP_RUN;
        end
      end
      RAMP_RUN: begin
        if (rampDone) begin
          rampClear = 1'b1; // RULE11
          rampCount_nxt = 16'h0000;
          rampSt_nxt = RAMP_DONE;
        end else if (rampSum >= {1'b0, rampTimeCyc}) begin
          rampAcc_nxt = rampSum - {1'b0, rampTimeCyc}; // RULE6
          if (rampIdx_r < RAMP_PAIRS_W) begin
            rampWrite = 1'b1; // RULE5
            rampIdx_nxt = rampIdx_r + 5'h01;
          end
        end else begin
          rampAcc_nxt = rampSum;
        end
      end
      RAMP_DONE: rampSt_nxt = RAMP_DONE;
      default: rampSt_nxt = RAMP_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rampSt_r <= RAMP_IDLE;
      rampTaken_r <= 1'b0;
      rampCount_r <= 16'h0000;
      rampIdx_r <= 5'h00;
      rampAcc_r <= 33'h0_0000_0000;
    end else begin
      rampSt_r <= rampSt_nxt;
      rampTaken_r <= rampTaken_nxt;
      rampCount_r <= rampCount_nxt;
      rampIdx_r <= rampIdx_nxt;
      rampAcc_r <= rampAcc_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Start-up status log
  pmd_stat_type statSt_r, statSt_nxt;
  logic [15:0] statMem_r [STATUS_WORDS];
  logic [4:0] statIdx_r, statIdx_nxt;
  logic [31:0] statTmr_r, statTmr_nxt;
  logic statWrite;

  always_comb begin
    statSt_nxt = statSt_r;
    statIdx_nxt = statIdx_r;
    statTmr_nxt = statTmr_r;
    statWrite = 1'b0;
    unique case (statSt_r)
      STAT_WAIT: begin
        if (rampDone) begin
          statSt_nxt = STAT_LOG; // RULE15
          statTmr_nxt = 32'h0000_0000;
        end
      end
      STAT_LOG: begin
        if (statTmr_r == 32'h0000_0000) begin
          statWrite = 1'b1; // RULE16
          statIdx_nxt = statIdx_r + 5'h01;
          statTmr_nxt = 32'(STATUS_INTERVAL - 1);
          if (statIdx_r == STATUS_WORDS_W - 5'h01) begin
            statSt_nxt = STAT_END; // RULE15
          end
        end else begin
          statTmr_nxt = statTmr_r - 32'h0000_0001;
        end
      end
      STAT_END: statSt_nxt = STAT_END;
      default: statSt_nxt = STAT_WAIT;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      statSt_r <= STAT_WAIT;
      statIdx_r <= 5'h00;
      statTmr_r <= 32'h0000_0000;
    end else begin
      statSt_r <= statSt_nxt;
      statIdx_r <= statIdx_nxt;
      statTmr_r <= statTmr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Log storage and read packing
  assign rampRead[15:0] = rampCount_r; // RULE7

  for (genvar i = 0; i < STATUS_WORDS; i++) begin : g_log
    always_ff @(posedge clock) begin
      if (rst) begin
        statMem_r[i] <= 16'h0000;
      end else if (statWrite && statIdx_r == 5'(i)) begin
        statMem_r[i] <= statusWord;
      end
    end
    assign statRead[16 * i +: 16] = statMem_r[i]; // RULE17
    if (i < RAMP_PAIRS) begin : g_ramp
      always_ff @(posedge clock) begin
        if (rst || rampClear) begin
          rampMem_r[i] <= 16'h0000;
        end else if (rampWrite && rampIdx_r == 5'(i)) begin
          rampMem_r[i] <= rampWrData;
        end
      end
      assign rampRead[RAMP_PAIR_LSB + 16 * i +: 16] = rampMem_r[i]; // RULE7
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_boot_entry: assert property (@(posedge clock) disable iff (rst) // RULE1
    req.valid && req.write && req.code == CMD_BOOT_MODE_ENTRY && req.len == LEN_BOOT
    |=> bootMode && resp.valid && resp.ack)
    else $error("boot entry not taken");
  a_share_enable: assert property (@(posedge clock) disable iff (rst) // RULE4
    req.valid && req.write && req.code == CMD_CURRENT_SHARE_THRESHOLD && req.len == LEN_SHARE
    |=> shareEnable == $past(req.data[SHARE_EN_BIT]))
    else $error("share enable does not follow bit 56");
  a_share_read: assert property (@(posedge clock) disable iff (rst) // RULE3
    req.valid && !req.write && req.code == CMD_CURRENT_SHARE_THRESHOLD
    |=> resp.ack && resp.len == LEN_SHARE && resp.data[63:0] == $past(shareThr_r))
    else $error("threshold readback wrong");
  a_ro_refused: assert property (@(posedge clock) disable iff (rst) // RULE19
    req.valid && req.write && isRoCmd |=> resp.valid && !resp.ack && $stable(rampCount_r))
    else $error("write to read-only command accepted");
  a_ramp_counter: assert property (@(posedge clock) disable iff (rst) // RULE9
    rampSt_r == RAMP_IDLE && rampStart && !rampTaken_r
    |=> rampCount_r == 16'($past(snapshotCount) + 16'h0001))
    else $error("ramp counter not snapshot plus one");
  a_ramp_once: assert property (@(posedge clock) disable iff (rst) // RULE10
    rampTaken_r && rampSt_r != RAMP_RUN |=> rampSt_r != RAMP_RUN)
    else $error("second ramp captured");
  a_ramp_clear: assert property (@(posedge clock) disable iff (rst) // RULE11
    rampSt_r == RAMP_RUN && rampDone |=> rampRead == '0 ##1 statSt_r == STAT_LOG)
    else $error("ramp log not cleared");
  a_ramp_limit: assert property (@(posedge clock) disable iff (rst) // RULE5
    rampIdx_r <= RAMP_PAIRS_W)
    else $error("more than 15 ramp pairs");
  a_temp_select: assert property (@(posedge clock) disable iff (rst) // RULE18
    !tempSel_r[TSEL_BIT] && $stable(tempSel_r) |=> primaryTemp == $past(intTemp)
    && secondaryTemp == $past(extTemp))
    else $error("temperature source mux wrong");
  a_status_span: assert property (@(posedge clock) disable iff (rst) // RULE16
    statWrite |-> statTmr_r == 32'h0000_0000 && statIdx_r < STATUS_WORDS_W)
    else $error("status sample out of window");

  c_boot: cover property (@(posedge clock) disable iff (rst) $rose(bootMode));
  c_ramp_full: cover property (@(posedge clock) disable iff (rst) rampIdx_r == RAMP_PAIRS_W);
  c_stat_end: cover property (@(posedge clock) disable iff (rst) statSt_r == STAT_END);
endmodule
`default_nettype wire

// ---- hw/pmd_pkg.sv ----
// Purpose: Shared constants and carriers for the manufacturer diagnostic command bank
// Assumes: PMBus framing, PEC and byte transport are handled by the protocol engine
// Notes: Block data is carried little end first, byte 0 in bits 7:0
package pmd_pkg;
  ////////////////////////////////////////////////////////////////////////////////
  // Command codes
  localparam logic [7:0] CMD_BOOT_MODE_ENTRY = 8'hD9;
  localparam logic [7:0] CMD_CURRENT_SHARE_THRESHOLD = 8'hDA;
  localparam logic [7:0] CMD_RAMP_CAPTURE_LOG = 8'hDB;
  localparam logic [7:0] CMD_TEMP_SOURCE_SELECT = 8'hDC;
  localparam logic [7:0] CMD_INPUT_OFFSET_TRIM = 8'hDD;
  localparam logic [7:0] CMD_OUTPUT_TRIM_MONITOR = 8'hDE;
  localparam logic [7:0] CMD_STARTUP_STATUS_LOG = 8'hDF;

  ////////////////////////////////////////////////////////////////////////////////
  // Transfer lengths in bytes
  localparam logic [5:0] LEN_BOOT = 6'h04;
  localparam logic [5:0] LEN_SHARE = 6'h08;
  localparam logic [5:0] LEN_RAMP = 6'h20;
  localparam logic [5:0] LEN_TSEL = 6'h01;
  localparam logic [5:0] LEN_VIN_OFS = 6'h04;
  localparam logic [5:0] LEN_VOUT_TRIM = 6'h02;
  localparam logic [5:0] LEN_STATUS = 6'h20;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int SHARE_EN_BIT = 56;
  localparam int TSEL_BIT = 0;
  localparam int VIN_OFS_ON_LSB = 16;
  localparam int RAMP_PAIR_LSB = 16;
  localparam logic [63:0] SHARE_RESET = 64'h0000_0000_0000_0000;
  localparam logic [7:0] TSEL_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Log geometry
  localparam int RAMP_PAIRS = 15;
  localparam logic [4:0] RAMP_PAIRS_W = 5'h0F;
  localparam int STATUS_WORDS = 16;
  localparam logic [4:0] STATUS_WORDS_W = 5'h10;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam longint CLK_HZ = 125_000_000;
  localparam longint STATUS_INTERVAL_S = 8;
  localparam longint STATUS_WINDOW_S = 128;
  localparam int STATUS_INTERVAL_CYC = int'(STATUS_INTERVAL_S * CLK_HZ);

  ////////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [5:0] len;
    logic [255:0] data;
  } pmd_req_type;

  typedef struct packed {
    logic valid;
    logic ack;
    logic [5:0] len;
    logic [255:0] data;
  } pmd_resp_type;

  typedef enum logic [1:0] {
    RAMP_IDLE = 2'b00,
    RAMP_RUN = 2'b01,
    RAMP_DONE = 2'b10
  } pmd_ramp_type;

  typedef enum logic [1:0] {
    STAT_WAIT = 2'b00,
    STAT_LOG = 2'b01,
    STAT_END = 2'b10
  } pmd_stat_type;
endpackage

// ---- test/pmd_host_model.sv ----
// Purpose: Management host model that issues one command at a time to the diagnostic bank
// Assumes: Calls start just after a clock edge or from time zero
// Notes: Released request fields carry the inverse of the last command, never a stale copy
`timescale 1ns/1ps
`default_nettype none
module pmd_host_model
  import pmd_pkg::*;
(
  // Clock
  input wire logic clock,
  // Command port
  output var pmd_req_type req,
  input wire pmd_resp_type resp
);
  pmd_resp_type last;

  initial req = '0;

  ////////////////////////////////////////////////////////////////////////////////
  // One command: the request is valid for a single cycle and then released, and the
  // response is taken 1 ns after the edge on which the bank answers it
  task automatic cmd(input logic wr, input logic [7:0] code, input logic [5:0] len,
                     input logic [255:0] data);
    @(posedge clock);
    req <= '{valid: 1'b1, write: wr, code: code, len: len, data: data};
    @(posedge clock);
    req <= '{valid: 1'b0, write: ~wr, code: ~code, len: ~len, data: ~data};
    #1;
    last = resp;
  endtask
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// Purpose: Self-checking bench for the manufacturer diagnostic command bank
// Assumes: Status interval shortened to 20 cycles; ramp time of 15, then 45 cycles
// Notes: Expected logs are built from the stimulus, never read back from the design
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pmd_pkg::*;
  localparam int INTERVAL = 20;
  logic clock = 1'b0;
  logic rst = 1'b1;
  pmd_req_type req;
  pmd_resp_type resp;
  logic rampStart = 1'b0;
  logic rampDone = 1'b0;
  logic [31:0] rampTimeCyc = 32'h0000_000F;
  logic [7:0] vinSample = 8'hA5;
  logic [7:0] voutSample = 8'h5A;
  logic [15:0] snapshotCount = 16'h0041;
  logic [15:0] statusWord = 16'hBEEF;
  logic [15:0] vinOffsetOn = 16'h1357;
  logic [15:0] vinOffsetOff = 16'h2468;
  logic [15:0] voutTrim = 16'hFF9C;
  logic [15:0] intTemp = 16'h0A11;
  logic [15:0] extTemp = 16'h0B22;
  logic bootMode;
  logic shareEnable;
  logic [15:0] primaryTemp;
  logic [15:0] secondaryTemp;
  int nErrors = 0;
  int nChecks = 0;
  int cycles = 0;
  logic [255:0] exp;
  logic [7:0] badCodes [7] = '{8'hDB, 8'hDC, 8'hDD, 8'hDE, 8'hDF, 8'hE0, 8'hD9};

  always #4 clock = ~clock;

  pmd_diag_bank #(.STATUS_INTERVAL(INTERVAL)) pmd_diag_bank_i (
    .clock(clock), .rst(rst), .req(req), .resp(resp),
    .rampStart(rampStart), .rampDone(rampDone), .rampTimeCyc(rampTimeCyc),
    .vinSample(vinSample), .voutSample(voutSample), .snapshotCount(snapshotCount),
    .statusWord(statusWord), .vinOffsetOn(vinOffsetOn), .vinOffsetOff(vinOffsetOff),
    .voutTrim(voutTrim), .intTemp(intTemp), .extTemp(extTemp), .bootMode(bootMode),
    .shareEnable(shareEnable), .primaryTemp(primaryTemp), .secondaryTemp(secondaryTemp)
  );

  pmd_host_model pmd_host_model_i (.clock(clock), .req(req), .resp(resp));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic endSim();
    $display("checks %0d mismatches %0d", nChecks, nErrors);
    if (nErrors == 0 && nChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [263:0] got, input logic [263:0] want, input string what);
    nChecks++;
    if (got !== want) begin
      nErrors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  // Any command, checking only that it is answered and accepted or refused
  task automatic acc(input logic wr, input logic [7:0] code, input logic [5:0] len,
                     input logic [255:0] data, input logic ack, input string what);
    pmd_host_model_i.cmd(wr, code, len, data);
    chk({pmd_host_model_i.last.valid, pmd_host_model_i.last.ack}, {1'b1, ack}, what);
  endtask

  task automatic rd(input logic [7:0] code, input logic [5:0] len, input logic [255:0] want,
                    input string what);
    acc(1'b0, code, 6'h00, '0, 1'b1, what);
    chk({pmd_host_model_i.last.len, pmd_host_model_i.last.data}, {len, want}, what);
  endtask

  task automatic strobe(input logic done);
    @(posedge clock);
    rampStart <= ~done;
    rampDone <= done;
    @(posedge clock);
    rampStart <= 1'b0;
    rampDone <= 1'b0;
  endtask

  // Run is about 580 cycles; the ceiling leaves ample margin
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      nErrors++;
      $display("wrong value at %0t: run did not finish", $time);
      endSim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(CMD_CURRENT_SHARE_THRESHOLD, LEN_SHARE, '0, "share reset");
    rd(CMD_TEMP_SOURCE_SELECT, LEN_TSEL, '0, "select reset");
    rd(CMD_INPUT_OFFSET_TRIM, LEN_VIN_OFS, {vinOffsetOn, vinOffsetOff}, "vin offset");
    rd(CMD_OUTPUT_TRIM_MONITOR, LEN_VOUT_TRIM, voutTrim, "vout trim");
    acc(1'b1, CMD_CURRENT_SHARE_THRESHOLD, LEN_SHARE, 64'h0100_0000_1234_5678, 1'b1, "thr");
    chk(shareEnable, 1'b1, "share on");
    rd(CMD_CURRENT_SHARE_THRESHOLD, LEN_SHARE, 64'h0100_0000_1234_5678, "thr back");
    acc(1'b1, CMD_CURRENT_SHARE_THRESHOLD, LEN_SHARE, 64'hFEFF_FFFF_FFFF_FFFF, 1'b1, "thr");
    chk(shareEnable, 1'b0, "share off");
    acc(1'b1, CMD_CURRENT_SHARE_THRESHOLD, 6'h07, '0, 1'b0, "short thr");
    rd(CMD_CURRENT_SHARE_THRESHOLD, LEN_SHARE, 64'hFEFF_FFFF_FFFF_FFFF, "thr kept");
    $display("test threshold done");
    foreach (badCodes[i]) begin
      acc(badCodes[i] != 8'hD9, badCodes[i], 6'h04, '1, 1'b0, "refused");
    end
    rd(CMD_INPUT_OFFSET_TRIM, LEN_VIN_OFS, {vinOffsetOn, vinOffsetOff}, "ofs kept");
    rd(CMD_TEMP_SOURCE_SELECT, LEN_TSEL, '0, "select kept");
    $display("test refusals done");
    acc(1'b1, CMD_TEMP_SOURCE_SELECT, LEN_TSEL, 8'h01, 1'b1, "select ext");
    repeat (2) @(posedge clock);
    chk({primaryTemp, secondaryTemp}, {extTemp, intTemp}, "ext primary");
    rd(CMD_TEMP_SOURCE_SELECT, LEN_TSEL, 8'h01, "select back");
    acc(1'b1, CMD_TEMP_SOURCE_SELECT, LEN_TSEL, 8'h00, 1'b1, "select int");
    repeat (2) @(posedge clock);
    chk({primaryTemp, secondaryTemp}, {intTemp, extTemp}, "int primary");
    $display("test sensor done");
    // Inputs stay constant over the ramp so every pair is known whatever the spacing
    exp = {240'h0, snapshotCount + 16'h0001};
    for (int i = 0; i < RAMP_PAIRS; i++) begin
      exp[RAMP_PAIR_LSB + 16 * i +: 16] = {voutSample, vinSample};
    end
    strobe(1'b0);
    repeat (40) @(posedge clock);
    rd(CMD_RAMP_CAPTURE_LOG, LEN_RAMP, exp, "ramp log");
    @(posedge clock);
    snapshotCount <= 16'h0100;
    vinSample <= 8'h11;
    voutSample <= 8'h22;
    strobe(1'b0);
    repeat (40) @(posedge clock);
    rd(CMD_RAMP_CAPTURE_LOG, LEN_RAMP, exp, "second ramp");
    strobe(1'b1);
    rd(CMD_RAMP_CAPTURE_LOG, LEN_RAMP, '0, "ramp cleared");
    $display("test ramp done");
    // Samples land 1, 21, 41 cycles after the done edge; the read sees three
    repeat (43) @(posedge clock);
    rd(CMD_STARTUP_STATUS_LOG, LEN_STATUS, {3{statusWord}}, "status partial");
    repeat (300) @(posedge clock);
    statusWord <= 16'h1234;
    repeat (60) @(posedge clock);
    rd(CMD_STARTUP_STATUS_LOG, LEN_STATUS, {16{16'hBEEF}}, "status full");
    strobe(1'b0);
    rd(CMD_RAMP_CAPTURE_LOG, LEN_RAMP, '0, "late ramp");
    $display("test status done");
    acc(1'b1, CMD_BOOT_MODE_ENTRY, 6'h03, 32'h5445_5354, 1'b0, "short boot");
    chk(bootMode, 1'b0, "no boot");
    acc(1'b1, CMD_BOOT_MODE_ENTRY, LEN_BOOT, 32'h5445_5354, 1'b1, "boot");
    chk(bootMode, 1'b1, "boot mode");
    $display("test boot done");
    // Power cycle: controls clear and a fresh ramp is captured at a slower pace
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rampTimeCyc <= 32'h0000_002D;
    chk({bootMode, shareEnable}, 2'b00, "controls after reset");
    rd(CMD_CURRENT_SHARE_THRESHOLD, LEN_SHARE, '0, "share after reset");
    // 45-cycle ramp: a pair every third cycle, five of them stored by the read
    exp = {240'h0, snapshotCount + 16'h0001};
    for (int i = 0; i < 5; i++) begin
      exp[RAMP_PAIR_LSB + 16 * i +: 16] = {voutSample, vinSample};
    end
    strobe(1'b0);
    repeat (14) @(posedge clock);
    rd(CMD_RAMP_CAPTURE_LOG, LEN_RAMP, exp, "ramp spacing");
    $display("test power cycle done");
    endSim();
  end
endmodule
`default_nettype wire
